// file: src/draf_pkg.sv
/*
  Package for the DRAM region access filter: register map, field layout,
  reset values and the request carrier.
  Assumes one clock (ref_clk, 10 MHz) and the APB-style register port.
*/
package draf_pkg;
  // ==========================================================
  // Widths
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int PADDR_W = 12;
  localparam int NUM_REGIONS = 16;
  localparam int IDX_W = 4;

  // ==========================================================
  // Register offsets
  localparam logic [PADDR_W-1:0] OFF_CONFIG = 12'h000;
  localparam logic [PADDR_W-1:0] OFF_INT_EN = 12'h004;
  localparam logic [PADDR_W-1:0] OFF_INT_STAT = 12'h008;
  localparam logic [PADDR_W-1:0] OFF_FAIL_ADDR = 12'h00C;
  localparam logic [PADDR_W-1:0] OFF_FAIL_CTRL = 12'h010;
  localparam logic [PADDR_W-1:0] OFF_LOCK = 12'h014;
  localparam logic [PADDR_W-1:0] OFF_GPR_NINE = 12'h018;
  localparam logic [PADDR_W-1:0] OFF_GPR_TEN = 12'h01C;
  localparam logic [PADDR_W-1:0] OFF_OCRAM_SPLIT = 12'h020;
  localparam logic [PADDR_W-1:0] OFF_REGION_BASE = 12'h100;
  localparam logic [PADDR_W-1:0] OFF_REGION_ATTR = 12'h104;
  localparam int REGION_STRIDE_LSB = 4;

  // ==========================================================
  // Fields
  localparam logic [DATA_W-1:0] CONFIG_VALUE = 32'h0000_0010;
  localparam int ATTR_EN_BIT = 0;
  localparam int ATTR_SIZE_LSB = 1;
  localparam int ATTR_SIZE_W = 6;
  localparam int ATTR_SUBDIS_LSB = 8;
  localparam int ATTR_PERM_LSB = 28;
  localparam int PERM_NS_WR = 0;
  localparam int PERM_NS_RD = 1;
  localparam int PERM_S_WR = 2;
  localparam int PERM_S_RD = 3;
  // Size code s gives a region of 2^(s+1) bytes; 14 is 32 KB
  localparam logic [ATTR_SIZE_W-1:0] MIN_SIZE_CODE = 6'h0E;
  localparam int GPR_NINE_BYPASS_BIT = 0;
  localparam int GPR_TEN_EN_BIT = 0;
  localparam int GPR_TEN_ID_SWAP_BIT = 1;
  localparam int GPR_TEN_EN_LOCK_BIT = 2;
  localparam int SPLIT_EN_BIT = 31;
  localparam logic [ADDR_W-1:0] OCRAM_BASE = 32'h0090_0000;
  localparam logic [ADDR_W-1:0] OCRAM_SIZE = 32'h0004_0000;

  // ==========================================================
  // Reset values
  localparam logic [DATA_W-1:0] ATTR_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

  // ==========================================================
  // Carrier
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic write;
    logic secure;
  } draf_req_t;
endpackage

// file: src/draf_filter.sv
/*
  DRAM region access filter: address-phase checker with sixteen
  prioritised regions, a register port, bypass/enable control and an
  on-chip RAM secure split.
  Assumes requesters and the register master run on ref_clk.
*/
`timescale 1ns/1ps
module draf_filter
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Register port
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [draf_pkg::PADDR_W-1:0] paddr,
  input wire logic [draf_pkg::DATA_W-1:0] pwdata,
  output logic [draf_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Requester side
  input wire logic sValid,
  input wire draf_pkg::draf_req_t sReq,
  output logic sReady,
  output logic sErr,
  // Memory side
  output logic mValid,
  output draf_pkg::draf_req_t mReq,
  input wire logic mReady,
  // Violation interrupt
  output logic irq
);

  // ==========================================================
  // Storage
  logic [draf_pkg::ADDR_W-1:0] regBase_q [draf_pkg::NUM_REGIONS];
  logic [draf_pkg::DATA_W-1:0] regAttr_q [draf_pkg::NUM_REGIONS];
  logic intEn_q;
  logic intStat_q;
  logic [draf_pkg::ADDR_W-1:0] failAddr_q;
  logic [1:0] failCtrl_q;
  logic lock_q;
  logic bypassOff_q;
  logic enable_q;
  logic idSwapBypass_q;
  logic enLock_q;
  logic [draf_pkg::DATA_W-1:0] split_q;
  logic idle_q;
  logic wrAcc;
  logic rdAcc;
  logic active;
  logic allow;
  logic take;
  logic deny;

  // ==========================================================
  // Decode
  function automatic logic isRegion(input logic [draf_pkg::PADDR_W-1:0] a,
                                    input logic [draf_pkg::PADDR_W-1:0] off);
    isRegion = (a[draf_pkg::PADDR_W-1:8] == off[draf_pkg::PADDR_W-1:8])
               && (a[3:0] == off[3:0]);
  endfunction

  function automatic logic [draf_pkg::IDX_W-1:0] regionIdx(input logic [draf_pkg::PADDR_W-1:0] a);
    regionIdx = a[draf_pkg::REGION_STRIDE_LSB +: draf_pkg::IDX_W];
  endfunction

  // Every access is taken in the cycle after its setup, one wait state
  assign wrAcc = psel && penable && !pready && pwrite;
  assign rdAcc = psel && penable && !pready && !pwrite;

  // ==========================================================
  // Region check
  function automatic logic checkAccess(input draf_pkg::draf_req_t r);
    logic [3:0] perm;
    logic [draf_pkg::ATTR_SIZE_W-1:0] sz;
    logic [draf_pkg::ADDR_W-1:0] diff;
    logic [2:0] sub;
    logic hit;
    perm = regAttr_q[0][draf_pkg::ATTR_PERM_LSB +: 4];
    sz = draf_pkg::MIN_SIZE_CODE;
    diff = '0;
    sub = '0;
    hit = 1'b0;
    // Ascending scan so the highest numbered hit overrides
    for (int i = 1; i < draf_pkg::NUM_REGIONS; i++)
    begin
      sz = regAttr_q[i][draf_pkg::ATTR_SIZE_LSB +: draf_pkg::ATTR_SIZE_W];
      if (sz < draf_pkg::MIN_SIZE_CODE)
        sz = draf_pkg::MIN_SIZE_CODE;
      diff = r.addr ^ regBase_q[i];
      sub = 3'((r.addr >> (sz - 6'h02)) & 32'h7);
      hit = regAttr_q[i][draf_pkg::ATTR_EN_BIT] && ((diff >> ({26'h0, sz} + 32'h1)) == '0)
            && !regAttr_q[i][draf_pkg::ATTR_SUBDIS_LSB + sub];
      if (hit)
        perm = regAttr_q[i][draf_pkg::ATTR_PERM_LSB +: 4];
    end
    if (r.secure)
      checkAccess = r.write ? perm[draf_pkg::PERM_S_WR] : perm[draf_pkg::PERM_S_RD];
    else
      checkAccess = r.write ? perm[draf_pkg::PERM_NS_WR] : perm[draf_pkg::PERM_NS_RD];
  endfunction

  function automatic logic ocramDeny(input draf_pkg::draf_req_t r);
    logic [draf_pkg::ADDR_W-1:0] off;
    off = r.addr - draf_pkg::OCRAM_BASE;
    // Upper part above the split is secure only
    ocramDeny = split_q[draf_pkg::SPLIT_EN_BIT] && !r.secure && (r.addr >= draf_pkg::OCRAM_BASE)
                && (off < draf_pkg::OCRAM_SIZE) && (off >= {1'b0, split_q[30:0]});
  endfunction

  // Either variant's control turns checking on
  assign active = bypassOff_q || enable_q;
  // A process, so region and split register changes re-evaluate the decision
  always_comb
  begin
    allow = (!active || checkAccess(sReq)) && !ocramDeny(sReq);
  end
  assign take = sValid && idle_q;
  assign deny = take && !allow;

  // ==========================================================
  // Request path
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      idle_q <= 1'b1;
      mValid <= 1'b0;
      mReq <= '0;
      sErr <= 1'b0;
    end
    else
    begin
      sErr <= deny;
      if (take)
      begin
        mValid <= allow;
        mReq <= sReq;
        idle_q <= !allow;
      end
      else if (mValid && mReady)
      begin
        mValid <= 1'b0;
        idle_q <= 1'b1;
      end
    end
  end

  assign sReady = idle_q;

  // ==========================================================
  // Violation status and interrupt
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      intStat_q <= 1'b0;
      failAddr_q <= '0;
      failCtrl_q <= '0;
      irq <= 1'b0;
    end
    else
    begin
      // A new violation wins over a clear in the same cycle
      if (deny)
      begin
        intStat_q <= 1'b1;
        failAddr_q <= sReq.addr;
        failCtrl_q <= {sReq.write, sReq.secure};
      end
      else if (wrAcc && paddr == draf_pkg::OFF_INT_STAT && pwdata[0])
      begin
        intStat_q <= 1'b0;
      end
      irq <= intStat_q && intEn_q;
    end
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      intEn_q <= 1'b0;
      lock_q <= 1'b0;
      bypassOff_q <= 1'b0;
      enable_q <= 1'b0;
      idSwapBypass_q <= 1'b0;
      enLock_q <= 1'b0;
      split_q <= draf_pkg::ZERO_WORD;
    end
    else if (wrAcc)
    begin
      if (paddr == draf_pkg::OFF_INT_EN)
        intEn_q <= pwdata[0];
      if (paddr == draf_pkg::OFF_LOCK && pwdata[0])
        lock_q <= 1'b1;
      if (paddr == draf_pkg::OFF_GPR_NINE && pwdata[draf_pkg::GPR_NINE_BYPASS_BIT])
        bypassOff_q <= 1'b1;
      if (paddr == draf_pkg::OFF_GPR_TEN)
      begin
        enable_q <= pwdata[draf_pkg::GPR_TEN_EN_BIT] || (enLock_q && enable_q);
        enLock_q <= enLock_q || pwdata[draf_pkg::GPR_TEN_EN_LOCK_BIT];
        idSwapBypass_q <= pwdata[draf_pkg::GPR_TEN_ID_SWAP_BIT];
      end
      if (paddr == draf_pkg::OFF_OCRAM_SPLIT && !lock_q)
      begin
        split_q <= pwdata;
      end
    end
  end

  // ==========================================================
  // Region registers
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < draf_pkg::NUM_REGIONS; i++)
      begin
        regBase_q[i] <= draf_pkg::ZERO_WORD;
        regAttr_q[i] <= draf_pkg::ATTR_RESET;
      end
    end
    else if (wrAcc && !lock_q)
    begin
      // Region zero covers everything; only its permission is writable
      if (isRegion(paddr, draf_pkg::OFF_REGION_BASE) && regionIdx(paddr) != '0)
      begin
        regBase_q[regionIdx(paddr)] <= pwdata;
      end
      if (isRegion(paddr, draf_pkg::OFF_REGION_ATTR))
      begin
        if (regionIdx(paddr) == '0)
        begin
          regAttr_q[0] <= {pwdata[31:28], 28'h0};
        end
        else
        begin
          regAttr_q[regionIdx(paddr)] <= pwdata;
        end
      end
    end
  end

  // ==========================================================
  // Register read
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prdata <= draf_pkg::ZERO_WORD;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && penable && !pready;
      pslverr <= 1'b0;
      prdata <= draf_pkg::ZERO_WORD;
      if (wrAcc || rdAcc)
      begin
        if (isRegion(paddr, draf_pkg::OFF_REGION_BASE))
        begin
          prdata <= rdAcc ? regBase_q[regionIdx(paddr)] : draf_pkg::ZERO_WORD;
        end
        else if (isRegion(paddr, draf_pkg::OFF_REGION_ATTR))
        begin
          prdata <= rdAcc ? regAttr_q[regionIdx(paddr)] : draf_pkg::ZERO_WORD;
        end
        else if (rdAcc)
        begin
          unique case (paddr)
            draf_pkg::OFF_CONFIG: prdata <= draf_pkg::CONFIG_VALUE;
            draf_pkg::OFF_INT_EN: prdata <= {31'h0, intEn_q};
            draf_pkg::OFF_INT_STAT: prdata <= {31'h0, intStat_q};
            draf_pkg::OFF_FAIL_ADDR: prdata <= failAddr_q;
            draf_pkg::OFF_FAIL_CTRL: prdata <= {30'h0, failCtrl_q};
            draf_pkg::OFF_LOCK: prdata <= {31'h0, lock_q};
            draf_pkg::OFF_GPR_NINE: prdata <= {31'h0, bypassOff_q};
            draf_pkg::OFF_GPR_TEN: prdata <= {29'h0, enLock_q, idSwapBypass_q, enable_q};
            draf_pkg::OFF_OCRAM_SPLIT: prdata <= split_q;
            default: pslverr <= 1'b1;
          endcase
        end
        else if (!(paddr inside {draf_pkg::OFF_INT_EN, draf_pkg::OFF_INT_STAT, draf_pkg::OFF_LOCK,
                   draf_pkg::OFF_GPR_NINE, draf_pkg::OFF_GPR_TEN, draf_pkg::OFF_OCRAM_SPLIT}))
        begin
          pslverr <= 1'b1;
        end
      end
    end
  end

endmodule

// file: tb/draf_mem_model.sv
/*
  Memory-side partner: takes forwarded requests at once or after a stall.
  Assumes mValid holds until mReady, all on ref_clk.
*/
`timescale 1ns/1ps
module draf_mem_model
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Handshake
  input wire logic mValid,
  input wire logic slowMode,
  output logic mReady
);
  logic [1:0] waitCnt_q;
  // Slow mode stalls three cycles so a held request is seen
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      waitCnt_q <= 2'h0;
    else if (!mValid || mReady)
      waitCnt_q <= 2'h0;
    else
      waitCnt_q <= waitCnt_q + 2'h1;
  end
  assign mReady = mValid && (!slowMode || waitCnt_q == 2'h3);
endmodule

// file: tb/draf_filter_checker.sv
/*
  Port checker for the DRAM region access filter.
  Assumes one clock domain and a register port with one wait state.
*/
`timescale 1ns/1ps
module draf_filter_checker
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Register port
  input wire logic psel,
  input wire logic penable,
  input wire logic [draf_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  // Request path
  input wire logic sValid,
  input wire draf_pkg::draf_req_t sReq,
  input wire logic sReady,
  input wire logic sErr,
  input wire logic mValid,
  input wire draf_pkg::draf_req_t mReq,
  input wire logic mReady
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  // ==========================================================
  // Register port
  a_wait_state: assert property ($rose(penable) && psel |=> pready)
    else $error("pready not one cycle after access");
  a_answer_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_idle_data: assert property (!pready |-> prdata == draf_pkg::ZERO_WORD)
    else $error("prdata not zero outside answer");
  // ==========================================================
  // Request path
  a_one_answer: assert property (sValid && sReady |=> mValid != sErr)
    else $error("taken request not forwarded or denied");
  a_hold_fwd: assert property (mValid && !mReady |=> mValid && $stable(mReq))
    else $error("forwarded request dropped before accept");
  a_fwd_addr: assert property (sValid && sReady ##1 mValid |-> mReq == $past(sReq))
    else $error("forwarded request differs from taken one");
  a_release_idle: assert property (mValid && mReady |=> !mValid && sReady)
    else $error("no release after accept");
  a_deny_idle: assert property (sErr |-> !mValid && sReady)
    else $error("denied request forwarded");
  c_deny: cover property (sErr);
  c_stall: cover property (mValid && !mReady);
  c_read: cover property (pready && prdata != draf_pkg::ZERO_WORD);
endmodule
bind draf_filter draf_filter_checker draf_filter_checker_inst (.ref_clk, .rstn, .psel, .penable, .prdata, .pready,
  .sValid, .sReq, .sReady, .sErr, .mValid, .mReq, .mReady);

// file: tb/draf_filter_test.sv
/*
  Testbench for the DRAM region access filter: register port, bypass,
  region priority, interrupt, lock and the on-chip RAM split.
  Assumes the memory-side model and the bound checker.
*/
`timescale 1ns/1ps
module draf_filter_test;
  typedef struct packed {
    logic [31:0] addr;
    logic sec;
    logic wr;
    logic deny;
  } draf_row_t;
  logic ref_clk, rstn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic sValid, sReady, sErr, mValid, mReady, irq, slowMode;
  draf_pkg::draf_req_t sReq, mReq;
  int err_total, num_checks;
  draf_row_t rows [7];
  draf_filter draf_filter_inst (.ref_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .sValid, .sReq, .sReady, .sErr, .mValid, .mReq, .mReady, .irq);
  draf_mem_model draf_mem_model_inst (.ref_clk, .rstn, .mValid, .slowMode, .mReady);
  // ==========================================================
  // Tasks
  task complete_run;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task waitfor(input logic ok);
    if (!ok)
    begin
      err_total++;
      complete_run();
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    #1;
    psel = 1'b1;
    pwrite = w;
    paddr = a;
    pwdata = d;
    @(posedge ref_clk);
    #1;
    penable = 1'b1;
    for (n = 0; n < 8 && pready !== 1'b1; n++)
    begin
      @(posedge ref_clk);
      #1;
    end
    waitfor(n < 8);
    rd = prdata;
    er = pslverr;
    @(posedge ref_clk);
    #1;
    psel = 1'b0;
    penable = 1'b0;
  endtask
  task req(input logic [31:0] a, input logic s, input logic w, input logic dn);
    int n;
    @(posedge ref_clk);
    #1;
    sReq.addr = a;
    sReq.secure = s;
    sReq.write = w;
    sValid = 1'b1;
    @(posedge ref_clk);
    #1;
    sValid = 1'b0;
    chk({sErr, mValid}, {dn, !dn});
    if (mValid === 1'b1)
      chk(mReq.addr, a);
    for (n = 0; n < 8 && mValid !== 1'b0; n++)
    begin
      @(posedge ref_clk);
      #1;
    end
    waitfor(n < 8);
  endtask
  // ==========================================================
  // Stimulus
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial
  begin
    rstn = 1'b0;
    {psel, penable, pwrite, sValid, slowMode} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    sReq = '0;
    rows = '{'{32'h8000_1000, 1'b0, 1'b0, 1'b0}, '{32'h8400_0000, 1'b0, 1'b1, 1'b1},
      '{32'h8400_0000, 1'b1, 1'b0, 1'b0}, '{32'h9000_0000, 1'b1, 1'b1, 1'b1},
      '{32'h0000_1000, 1'b0, 1'b0, 1'b1}, '{32'h9FE0_7FFC, 1'b1, 1'b0, 1'b0},
      '{32'h9FE0_8000, 1'b1, 1'b0, 1'b1}};
    repeat (12) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    chk({sReady, mValid, sErr, irq, pready}, 5'h10);
    apb(1'b0, draf_pkg::OFF_CONFIG, 32'h0);
    chk(rd, 32'h0000_0010);
    apb(1'b1, draf_pkg::OFF_CONFIG, 32'h0);
    chk(er, 1'b1);
    apb(1'b1, 12'h800, 32'h0);
    chk(er, 1'b1);
    apb(1'b0, 12'h104, 32'h0);
    chk(rd, 32'h0);
    // Stalled accept while nothing is checked yet
    slowMode = 1'b1;
    req(32'h0000_1000, 1'b0, 1'b1, 1'b0);
    slowMode = 1'b0;
    apb(1'b1, draf_pkg::OFF_OCRAM_SPLIT, 32'h8003_8000);
    req(32'h0090_0000, 1'b0, 1'b0, 1'b0);
    req(32'h0093_8000, 1'b0, 1'b0, 1'b1);
    req(32'h0093_8000, 1'b1, 1'b0, 1'b0);
    apb(1'b1, 12'h110, 32'h8000_0000);
    apb(1'b1, 12'h114, 32'h3000_0039);
    apb(1'b1, 12'h120, 32'h8400_0000);
    apb(1'b1, 12'h124, 32'hC000_0031);
    apb(1'b1, 12'h130, 32'h9FE0_0000);
    apb(1'b1, 12'h134, 32'hF000_0001);
    apb(1'b1, draf_pkg::OFF_GPR_NINE, 32'h1);
    apb(1'b1, draf_pkg::OFF_GPR_NINE, 32'h0);
    apb(1'b0, draf_pkg::OFF_GPR_NINE, 32'h0);
    chk(rd & 32'h1, 32'h1);
    foreach (rows[i])
      req(rows[i].addr, rows[i].sec, rows[i].wr, rows[i].deny);
    // Disabled eighth seven hands the access back to region one
    apb(1'b1, 12'h134, 32'hF000_8001);
    req(32'h9FE0_7FFC, 1'b1, 1'b0, 1'b1);
    // Earlier denials left the status set; clear it so the new one is seen
    apb(1'b1, draf_pkg::OFF_INT_STAT, 32'h1);
    apb(1'b1, draf_pkg::OFF_INT_EN, 32'h1);
    chk(irq, 1'b0);
    req(32'h0000_2000, 1'b1, 1'b1, 1'b1);
    @(posedge ref_clk);
    #1;
    chk(irq, 1'b1);
    apb(1'b0, draf_pkg::OFF_FAIL_ADDR, 32'h0);
    chk(rd, 32'h0000_2000);
    apb(1'b0, draf_pkg::OFF_FAIL_CTRL, 32'h0);
    chk(rd, 32'h0000_0003);
    apb(1'b1, draf_pkg::OFF_INT_STAT, 32'h1);
    chk(irq, 1'b0);
    apb(1'b1, draf_pkg::OFF_INT_EN, 32'h0);
    req(32'h0000_2000, 1'b0, 1'b0, 1'b1);
    @(posedge ref_clk);
    #1;
    chk(irq, 1'b0);
    apb(1'b1, draf_pkg::OFF_LOCK, 32'h1);
    apb(1'b1, 12'h114, 32'h0);
    req(32'h8000_1000, 1'b0, 1'b0, 1'b0);
    // Without the lock the enable can still be cleared
    apb(1'b1, draf_pkg::OFF_GPR_TEN, 32'h1);
    apb(1'b1, draf_pkg::OFF_GPR_TEN, 32'h0);
    apb(1'b0, draf_pkg::OFF_GPR_TEN, 32'h0);
    chk(rd, 32'h0000_0000);
    apb(1'b1, draf_pkg::OFF_GPR_TEN, 32'h7);
    apb(1'b0, draf_pkg::OFF_GPR_TEN, 32'h0);
    chk(rd, 32'h0000_0007);
    apb(1'b1, draf_pkg::OFF_GPR_TEN, 32'h0);
    apb(1'b0, draf_pkg::OFF_GPR_TEN, 32'h0);
    chk(rd, 32'h0000_0005);
    // Reset in mid-run clears the sticky controls and stops checking
    @(posedge ref_clk);
    #1;
    rstn = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    chk({sReady, mValid, sErr, irq, pready}, 5'h10);
    apb(1'b0, draf_pkg::OFF_GPR_NINE, 32'h0);
    chk(rd, 32'h0000_0000);
    apb(1'b0, draf_pkg::OFF_GPR_TEN, 32'h0);
    chk(rd, 32'h0000_0000);
    req(32'h0000_1000, 1'b0, 1'b1, 1'b0);
    complete_run();
  end
endmodule
